// >>> inc/dsf_pkg.sv
/*
 * Shared constants and carrier types for the dual 9-bit synchronous FIFO.
 * Assumes every user writes dsf_pkg::name; nothing is imported.
 */
package dsf_pkg;

    localparam int DSF_DATA_W     = 9;
    localparam int DSF_DEPTH_DEF  = 256;
    localparam int DSF_OFFSET_DEF = 7;
    localparam int DSF_NUM_CH     = 2;
    localparam int DSF_CH_A       = 0;
    localparam int DSF_CH_B       = 1;

    // one buffer's pin inputs, used both raw at the ports and as seen after synchronisation
    typedef struct packed {
        logic                  reset_n;
        logic                  write_clock;
        logic                  read_clock;
        logic                  write_enable_first;
        logic                  second_write_enable_or_load;
        logic                  read_enable_first;
        logic                  read_enable_second;
        logic                  output_enable_n;
        logic [DSF_DATA_W-1:0] write_data_in;
    } dsf_pins_t;

    localparam int DSF_PIN_W = $bits(dsf_pins_t);

    // one buffer's registered outputs
    typedef struct packed {
        logic [DSF_DATA_W-1:0] read_data_out;
        logic                  read_data_oe_n;
        logic                  empty_flag;
        logic                  full_flag;
        logic                  almost_empty_flag;
        logic                  almost_full_flag;
    } dsf_outs_t;

endpackage : dsf_pkg

// >>> core/dsf_pin_sync.sv
/*
 * Two-flop synchroniser for a bundle of pin inputs, plus a third stage
 * so the caller can find edges of slow pin clocks.
 * Assumes pins change much slower than ref_clk_i.
 */
`timescale 1ns/1ps

module dsf_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o,
    output logic      [W-1:0] q_prev_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } dsf_psync_t;

    dsf_psync_t st;
    dsf_psync_t next_st;

    always_comb begin
        next_st      = st;
        next_st.meta = d_i;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign q_o      = st.sync;
    assign q_prev_o = st.prev;

endmodule : dsf_pin_sync

// >>> core/dsf_gray_sync.sv
/*
 * Two-stage synchroniser for a gray-coded pointer passed between the
 * write side and the read side of one buffer.
 * Assumes the source changes by at most one bit per sampling edge.
 */
`timescale 1ns/1ps

module dsf_gray_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } dsf_gsync_t;

    dsf_gsync_t st;
    dsf_gsync_t next_st;

    always_comb begin
        next_st      = st;
        next_st.meta = d_i;
        next_st.sync = st.meta;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign q_o = st.sync;

endmodule : dsf_gray_sync

// >>> core/dsf_dual_fifo.sv
/*
 * Dual independent 9-bit synchronous FIFO: two buffers, each with its own
 * write clock, read clock, enables, reset, output enable and four flags.
 * Assumes pin clocks are sampled on ref_clk_i and run well below half its
 * rate; all pins are treated as asynchronous and synchronised first.
 */
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module dsf_dual_fifo #(
    parameter int DEPTH = dsf_pkg::DSF_DEPTH_DEF
) (
    input  wire logic                            ref_clk_i,
    input  wire logic                            sys_rst_i,
    input  wire logic                            ce_i,
    input  wire logic                            reset_n_a_i,
    input  wire logic                            write_clock_a_i,
    input  wire logic                            read_clock_a_i,
    input  wire logic                            write_enable_first_a_i,
    input  wire logic                            second_write_enable_or_load_a_i,
    input  wire logic                            read_enable_first_a_i,
    input  wire logic                            read_enable_second_a_i,
    input  wire logic                            output_enable_n_a_i,
    input  wire logic [dsf_pkg::DSF_DATA_W-1:0]  write_data_in_a_i,
    output logic      [dsf_pkg::DSF_DATA_W-1:0]  read_data_out_a_o,
    output logic                                 read_data_oe_n_a_o,
    output logic                                 empty_flag_a_o,
    output logic                                 full_flag_a_o,
    output logic                                 almost_empty_flag_a_o,
    output logic                                 almost_full_flag_a_o,
    input  wire logic                            reset_n_b_i,
    input  wire logic                            write_clock_b_i,
    input  wire logic                            read_clock_b_i,
    input  wire logic                            write_enable_first_b_i,
    input  wire logic                            second_write_enable_or_load_b_i,
    input  wire logic                            read_enable_first_b_i,
    input  wire logic                            read_enable_second_b_i,
    input  wire logic                            output_enable_n_b_i,
    input  wire logic [dsf_pkg::DSF_DATA_W-1:0]  write_data_in_b_i,
    output logic      [dsf_pkg::DSF_DATA_W-1:0]  read_data_out_b_o,
    output logic                                 read_data_oe_n_b_o,
    output logic                                 empty_flag_b_o,
    output logic                                 full_flag_b_o,
    output logic                                 almost_empty_flag_b_o,
    output logic                                 almost_full_flag_b_o
);

    localparam int DW = dsf_pkg::DSF_DATA_W;
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;

    localparam logic [PW-1:0] DEPTH_P   = PW'(DEPTH);
    localparam logic [AW-1:0] OFF_DEF_P = AW'(dsf_pkg::DSF_OFFSET_DEF);
    localparam logic [PW-1:0] PTR_ONE   = PW'(1);

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i + 1]);
        end
        gray2bin = b;
    endfunction : gray2bin

    dsf_pkg::dsf_pins_t pins_raw [dsf_pkg::DSF_NUM_CH];
    dsf_pkg::dsf_outs_t outs     [dsf_pkg::DSF_NUM_CH];

    // pin bundles, one per buffer
    always_comb begin
        pins_raw[dsf_pkg::DSF_CH_A] = '{
            reset_n:                     reset_n_a_i,
            write_clock:                 write_clock_a_i,
            read_clock:                  read_clock_a_i,
            write_enable_first:          write_enable_first_a_i,
            second_write_enable_or_load: second_write_enable_or_load_a_i,
            read_enable_first:           read_enable_first_a_i,
            read_enable_second:          read_enable_second_a_i,
            output_enable_n:             output_enable_n_a_i,
            write_data_in:               write_data_in_a_i
        };
        pins_raw[dsf_pkg::DSF_CH_B] = '{
            reset_n:                     reset_n_b_i,
            write_clock:                 write_clock_b_i,
            read_clock:                  read_clock_b_i,
            write_enable_first:          write_enable_first_b_i,
            second_write_enable_or_load: second_write_enable_or_load_b_i,
            read_enable_first:           read_enable_first_b_i,
            read_enable_second:          read_enable_second_b_i,
            output_enable_n:             output_enable_n_b_i,
            write_data_in:               write_data_in_b_i
        };
    end

    for (genvar c = 0; c < dsf_pkg::DSF_NUM_CH; c++) begin : g_ch

        typedef struct packed {
            logic          two_we_mode;
            logic [PW-1:0] wbin;
            logic [PW-1:0] wgray;
            logic [PW-1:0] rbin;
            logic [PW-1:0] rgray;
            logic [AW-1:0] empty_off;
            logic [AW-1:0] full_off;
            logic          ld_wsel;
            logic          ld_rsel;
            dsf_pkg::dsf_outs_t o;
        } dsf_ch_state_t;

        dsf_ch_state_t       st;
        dsf_ch_state_t       next_st;
        logic [DW-1:0]       mem [DEPTH];
        logic [dsf_pkg::DSF_PIN_W-1:0] p_vec;
        logic [dsf_pkg::DSF_PIN_W-1:0] p_prev_vec;
        dsf_pkg::dsf_pins_t  p;
        dsf_pkg::dsf_pins_t  p_prev;
        logic                wrise;
        logic                rrise;
        logic                chan_rst;
        logic                load_sel;
        logic                wr_en;
        logic [AW-1:0]       wr_addr;
        logic [PW-1:0]       wgray_at_rd;
        logic [PW-1:0]       rgray_at_wr;
        logic [PW-1:0]       fill_w;
        logic [PW-1:0]       fill_r;

        dsf_pin_sync #(
            .W(dsf_pkg::DSF_PIN_W)
        ) u_pins (
            .ref_clk_i (ref_clk_i),
            .sys_rst_i (sys_rst_i),
            .ce_i      (ce_i),
            .d_i       (pins_raw[c]),
            .q_o       (p_vec),
            .q_prev_o  (p_prev_vec)
        );

        assign p        = dsf_pkg::dsf_pins_t'(p_vec);
        assign p_prev   = dsf_pkg::dsf_pins_t'(p_prev_vec);
        assign wrise    = p.write_clock & ~p_prev.write_clock;
        assign rrise    = p.read_clock & ~p_prev.read_clock;
        assign chan_rst = sys_rst_i | ~p.reset_n;
        assign load_sel = ~st.two_we_mode & ~p.second_write_enable_or_load;

        // pointer crossings between write and read sides
        dsf_gray_sync #(
            .W(PW)
        ) u_w2r (
            .ref_clk_i (ref_clk_i),
            .rst_i     (chan_rst),
            .ce_i      (ce_i),
            .d_i       (st.wgray),
            .q_o       (wgray_at_rd)
        );

        dsf_gray_sync #(
            .W(PW)
        ) u_r2w (
            .ref_clk_i (ref_clk_i),
            .rst_i     (chan_rst),
            .ce_i      (ce_i),
            .d_i       (st.rgray),
            .q_o       (rgray_at_wr)
        );

        always_comb begin
            next_st = st;
            wr_en   = 1'b0;
            wr_addr = st.wbin[AW-1:0];
            fill_w  = '0;
            fill_r  = '0;
            if (chan_rst) begin
                next_st.wbin                = '0;
                next_st.wgray               = '0;
                next_st.rbin                = '0;
                next_st.rgray               = '0;
                next_st.empty_off           = OFF_DEF_P;
                next_st.full_off            = OFF_DEF_P;
                next_st.ld_wsel             = 1'b0;
                next_st.ld_rsel             = 1'b0;
                next_st.o.read_data_out     = '0;
                next_st.o.full_flag         = 1'b1;
                next_st.o.almost_full_flag  = 1'b1;
                next_st.o.empty_flag        = 1'b0;
                next_st.o.almost_empty_flag = 1'b0;
                next_st.o.read_data_oe_n    = p.output_enable_n;
                next_st.two_we_mode         = p.second_write_enable_or_load;
                if (sys_rst_i) begin
                    next_st.o.read_data_oe_n = 1'b1;
                    next_st.two_we_mode      = 1'b1;
                end
            end else begin
                next_st.o.read_data_oe_n = p.output_enable_n;
                if (wrise) begin
                    if (load_sel) begin
                        if (!p.write_enable_first) begin
                            if (!st.ld_wsel) begin
                                next_st.empty_off = AW'(p.write_data_in);
                            end else begin
                                next_st.full_off = AW'(p.write_data_in);
                            end
                            next_st.ld_wsel = ~st.ld_wsel;
                        end
                    end else if (!p.write_enable_first
                                 && (!st.two_we_mode || p.second_write_enable_or_load)
                                 && st.o.full_flag) begin
                        wr_en         = 1'b1;
                        next_st.wbin  = st.wbin + PTR_ONE;
                        next_st.wgray = bin2gray(st.wbin + PTR_ONE);
                    end
                    fill_w = next_st.wbin - gray2bin(rgray_at_wr);
                    next_st.o.full_flag        = (fill_w != DEPTH_P);
                    next_st.o.almost_full_flag =
                        ((DEPTH_P - fill_w) > PW'(next_st.full_off));
                end
                if (rrise) begin
                    if (load_sel) begin
                        if (!p.read_enable_first && !p.read_enable_second) begin
                            next_st.o.read_data_out = st.ld_rsel ? DW'(st.full_off)
                                                                 : DW'(st.empty_off);
                            next_st.ld_rsel = ~st.ld_rsel;
                        end
                    end else if (!p.read_enable_first && !p.read_enable_second
                                 && st.o.empty_flag) begin
                        next_st.o.read_data_out = mem[st.rbin[AW-1:0]];
                        next_st.rbin  = st.rbin + PTR_ONE;
                        next_st.rgray = bin2gray(st.rbin + PTR_ONE);
                    end
                    fill_r = gray2bin(wgray_at_rd) - next_st.rbin;
                    next_st.o.empty_flag        = (fill_r != '0);
                    next_st.o.almost_empty_flag =
                        (fill_r > PW'(next_st.empty_off));
                end
            end
        end

        always_ff @(posedge ref_clk_i) begin
            if (ce_i) begin
                st <= next_st;
            end
        end

        // storage is not reset; pointers define what is valid
        always_ff @(posedge ref_clk_i) begin
            if (ce_i && wr_en) begin
                mem[wr_addr] <= p.write_data_in;
            end
        end

        assign outs[c] = st.o;

    end : g_ch

    assign read_data_out_a_o     = outs[dsf_pkg::DSF_CH_A].read_data_out;
    assign read_data_oe_n_a_o    = outs[dsf_pkg::DSF_CH_A].read_data_oe_n;
    assign empty_flag_a_o        = outs[dsf_pkg::DSF_CH_A].empty_flag;
    assign full_flag_a_o         = outs[dsf_pkg::DSF_CH_A].full_flag;
    assign almost_empty_flag_a_o = outs[dsf_pkg::DSF_CH_A].almost_empty_flag;
    assign almost_full_flag_a_o  = outs[dsf_pkg::DSF_CH_A].almost_full_flag;
    assign read_data_out_b_o     = outs[dsf_pkg::DSF_CH_B].read_data_out;
    assign read_data_oe_n_b_o    = outs[dsf_pkg::DSF_CH_B].read_data_oe_n;
    assign empty_flag_b_o        = outs[dsf_pkg::DSF_CH_B].empty_flag;
    assign full_flag_b_o         = outs[dsf_pkg::DSF_CH_B].full_flag;
    assign almost_empty_flag_b_o = outs[dsf_pkg::DSF_CH_B].almost_empty_flag;
    assign almost_full_flag_b_o  = outs[dsf_pkg::DSF_CH_B].almost_full_flag;

endmodule : dsf_dual_fifo

// >>> bench/dsf_fifo_properties.sv
/*
 * Checker for buffer a of the dual fifo: flag timing, reset values, output enable.
 * Assumes pin clocks hold each level for several ref cycles.
 */
`timescale 1ns/1ps

module dsf_fifo_checker (
    input wire logic                           ref_clk_i,
    input wire logic                           sys_rst_i,
    input wire logic                           reset_n_a_i,
    input wire logic                           write_clock_a_i,
    input wire logic                           read_clock_a_i,
    input wire logic                           second_write_enable_or_load_a_i,
    input wire logic                           output_enable_n_a_i,
    input wire logic [dsf_pkg::DSF_DATA_W-1:0] read_data_out_a_o,
    input wire logic                           read_data_oe_n_a_o,
    input wire logic                           empty_flag_a_o,
    input wire logic                           full_flag_a_o,
    input wire logic                           almost_empty_flag_a_o,
    input wire logic                           almost_full_flag_a_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // buffer out of reset long enough for its outputs to settle
    sequence s_live;
        reset_n_a_i [*5];
    endsequence
    sequence s_wclk;
        write_clock_a_i || $past(write_clock_a_i);
    endsequence
    sequence s_rclk;
        read_clock_a_i || $past(read_clock_a_i);
    endsequence
    property p_held;
        s_live ##0 (!empty_flag_a_o && !$past(empty_flag_a_o) && second_write_enable_or_load_a_i)
            |-> $stable(read_data_out_a_o);
    endproperty
    property p_reset;
        (!reset_n_a_i) [*5] |-> full_flag_a_o && almost_full_flag_a_o && !empty_flag_a_o
            && !almost_empty_flag_a_o && read_data_out_a_o == 9'h000;
    endproperty
    property p_oe;
        $stable(output_enable_n_a_i) [*6] |-> read_data_oe_n_a_o == output_enable_n_a_i;
    endproperty

    a_full_on_wclk: assert property (s_live ##0 $changed(full_flag_a_o) |-> s_wclk)
        else $error("full flag moved without a write clock");
    a_afull_on_wclk: assert property (s_live ##0 $changed(almost_full_flag_a_o) |-> s_wclk)
        else $error("almost-full flag moved without a write clock");
    a_empty_on_rclk: assert property (s_live ##0 $changed(empty_flag_a_o) |-> s_rclk)
        else $error("empty flag moved without a read clock");
    a_aempty_on_rclk: assert property (s_live ##0 $changed(almost_empty_flag_a_o) |-> s_rclk)
        else $error("almost-empty flag moved without a read clock");
    a_data_on_rclk: assert property (s_live ##0 $changed(read_data_out_a_o) |-> s_rclk)
        else $error("output moved without a read clock");
    a_empty_holds_data: assert property (p_held)
        else $error("output moved while empty");
    a_full_implies_af: assert property (!full_flag_a_o |-> !almost_full_flag_a_o)
        else $error("full without almost-full");
    a_empty_implies_ae: assert property (!empty_flag_a_o |-> !almost_empty_flag_a_o)
        else $error("empty without almost-empty");
    a_reset_values: assert property (p_reset)
        else $error("wrong outputs during buffer reset");
    a_oe_follows: assert property (p_oe)
        else $error("output enable does not follow its pin");
endmodule : dsf_fifo_checker

bind dsf_dual_fifo dsf_fifo_checker u_checker (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reset_n_a_i(reset_n_a_i),
    .write_clock_a_i(write_clock_a_i), .read_clock_a_i(read_clock_a_i),
    .second_write_enable_or_load_a_i(second_write_enable_or_load_a_i),
    .output_enable_n_a_i(output_enable_n_a_i), .read_data_out_a_o(read_data_out_a_o),
    .read_data_oe_n_a_o(read_data_oe_n_a_o), .empty_flag_a_o(empty_flag_a_o),
    .full_flag_a_o(full_flag_a_o), .almost_empty_flag_a_o(almost_empty_flag_a_o),
    .almost_full_flag_a_o(almost_full_flag_a_o)
);

// >>> bench/dsf_far_side.sv
/*
 * Writer and reader logic for one buffer port, with the output bus resolved.
 * Assumes each task is entered just after a rising ref clock edge.
 */
`timescale 1ns/1ps

module dsf_far_side (
    input  wire logic                           ref_clk_i,
    input  wire dsf_pkg::dsf_outs_t             outs_i,
    output dsf_pkg::dsf_pins_t                  pins_o,
    output wire logic [dsf_pkg::DSF_DATA_W-1:0] q_bus_o
);
    // bus floats while the buffer does not drive it
    assign q_bus_o = outs_i.read_data_oe_n ? 9'hZZZ : outs_i.read_data_out;

    initial begin
        pins_o = '0;
        pins_o.write_enable_first = 1'b1;
        pins_o.read_enable_first = 1'b1;
        pins_o.read_enable_second = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : hold

    // load level seen last before release picks the mode
    task automatic rst(input logic ld);
        pins_o.reset_n <= 1'b0;
        pins_o.second_write_enable_or_load <= ld;
        hold(8);
        pins_o.reset_n <= 1'b1;
        hold(6);
    endtask : rst

    // one write clock period, six ref cycles per level
    task automatic wr(input logic e1, input logic e2, input logic [8:0] d);
        pins_o.write_enable_first <= e1;
        pins_o.second_write_enable_or_load <= e2;
        pins_o.write_data_in <= d;
        pins_o.write_clock <= 1'b1;
        hold(6);
        pins_o.write_clock <= 1'b0;
        pins_o.write_data_in <= ~d;
        hold(6);
    endtask : wr

    task automatic rd(input logic e1, input logic e2);
        pins_o.read_enable_first <= e1;
        pins_o.read_enable_second <= e2;
        pins_o.read_clock <= 1'b1;
        hold(6);
        pins_o.read_clock <= 1'b0;
        hold(6);
    endtask : rd

    task automatic oe(input logic v);
        pins_o.output_enable_n <= v;
        hold(6);
    endtask : oe
endmodule : dsf_far_side

// >>> bench/dsf_dual_fifo_tb.sv
/*
 * Self-checking bench for the dual fifo: order, refusals, flags, offsets.
 * Assumes a far-side model per buffer drives its pins.
 */
`timescale 1ns/1ps

module dsf_dual_fifo_tb;
    logic                    ref_clk_i;
    logic                    sys_rst_i;
    logic                    ce;
    int                      fail_count;
    int                      checks_done;
    wire dsf_pkg::dsf_pins_t pa;
    wire dsf_pkg::dsf_pins_t pb;
    wire dsf_pkg::dsf_outs_t oa;
    wire dsf_pkg::dsf_outs_t ob;
    wire logic [8:0]         qa;
    wire logic [8:0]         qb;

    dsf_dual_fifo u_dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .reset_n_a_i(pa.reset_n), .write_clock_a_i(pa.write_clock),
        .read_clock_a_i(pa.read_clock), .write_enable_first_a_i(pa.write_enable_first),
        .second_write_enable_or_load_a_i(pa.second_write_enable_or_load),
        .read_enable_first_a_i(pa.read_enable_first),
        .read_enable_second_a_i(pa.read_enable_second),
        .output_enable_n_a_i(pa.output_enable_n), .write_data_in_a_i(pa.write_data_in),
        .read_data_out_a_o(oa.read_data_out), .read_data_oe_n_a_o(oa.read_data_oe_n),
        .empty_flag_a_o(oa.empty_flag), .full_flag_a_o(oa.full_flag),
        .almost_empty_flag_a_o(oa.almost_empty_flag), .almost_full_flag_a_o(oa.almost_full_flag),
        .reset_n_b_i(pb.reset_n), .write_clock_b_i(pb.write_clock),
        .read_clock_b_i(pb.read_clock), .write_enable_first_b_i(pb.write_enable_first),
        .second_write_enable_or_load_b_i(pb.second_write_enable_or_load),
        .read_enable_first_b_i(pb.read_enable_first),
        .read_enable_second_b_i(pb.read_enable_second),
        .output_enable_n_b_i(pb.output_enable_n), .write_data_in_b_i(pb.write_data_in),
        .read_data_out_b_o(ob.read_data_out), .read_data_oe_n_b_o(ob.read_data_oe_n),
        .empty_flag_b_o(ob.empty_flag), .full_flag_b_o(ob.full_flag),
        .almost_empty_flag_b_o(ob.almost_empty_flag), .almost_full_flag_b_o(ob.almost_full_flag)
    );
    dsf_far_side u_fa (.ref_clk_i(ref_clk_i), .outs_i(oa), .pins_o(pa), .q_bus_o(qa));
    dsf_far_side u_fb (.ref_clk_i(ref_clk_i), .outs_i(ob), .pins_o(pb), .q_bus_o(qb));

    // full, almost-full, empty, almost-empty in the low four bits
    function automatic logic [8:0] flags(input dsf_pkg::dsf_outs_t o);
        return {5'h00, o.full_flag, o.almost_full_flag, o.empty_flag, o.almost_empty_flag};
    endfunction : flags

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic t_reset;
        chk("flags a", 9'h00C, flags(oa));
        chk("flags b", 9'h00C, flags(ob));
        chk("data a", 9'h000, oa.read_data_out);
    endtask : t_reset

    task automatic t_order;
        u_fa.wr(1'b0, 1'b0, 9'h1AA);
        u_fa.wr(1'b1, 1'b1, 9'h0FF);
        u_fa.wr(1'b0, 1'b1, 9'h155);
        u_fa.wr(1'b0, 1'b1, 9'h0AB);
        u_fa.rd(1'b1, 1'b1);
        chk("flags a", 9'h00E, flags(oa));
        u_fa.rd(1'b0, 1'b1);
        chk("data a", 9'h000, oa.read_data_out);
        u_fa.rd(1'b0, 1'b0);
        chk("data a", 9'h155, oa.read_data_out);
        u_fa.rd(1'b0, 1'b0);
        chk("data a", 9'h0AB, oa.read_data_out);
        u_fa.rd(1'b0, 1'b0);
        chk("data a", 9'h0AB, oa.read_data_out);
        chk("flags a", 9'h00C, flags(oa));
        chk("flags b", 9'h00C, flags(ob));
        u_fa.oe(1'b1);
        chk("bus a", 9'hZZZ, qa);
        u_fa.oe(1'b0);
        chk("bus a", 9'h0AB, qa);
    endtask : t_order

    task automatic t_fill;
        for (int i = 0; i < 256; i++) begin
            u_fa.wr(1'b0, 1'b1, 9'(i));
            if (i == 6 || i == 7) begin
                u_fa.rd(1'b1, 1'b1);
                chk("flags a", (i == 6) ? 9'h00E : 9'h00F, flags(oa));
            end
            if (i == 247 || i == 248) begin
                chk("flags a", (i == 247) ? 9'h00F : 9'h00B, flags(oa));
            end
        end
        chk("flags a", 9'h003, flags(oa));
        u_fa.wr(1'b0, 1'b1, 9'h1FF);
        chk("flags a", 9'h003, flags(oa));
        u_fa.rd(1'b0, 1'b0);
        chk("data a", 9'h000, oa.read_data_out);
        u_fa.wr(1'b1, 1'b1, 9'h000);
        chk("flags a", 9'h00B, flags(oa));
        for (int i = 1; i < 256; i++) begin
            u_fa.rd(1'b0, 1'b0);
            chk("data a", 9'(i), oa.read_data_out);
        end
        chk("flags a", 9'h008, flags(oa));
    endtask : t_fill

    task automatic t_load;
        u_fb.wr(1'b0, 1'b0, 9'h002);
        u_fb.wr(1'b0, 1'b0, 9'h003);
        u_fb.rd(1'b0, 1'b0);
        chk("offset b", 9'h002, ob.read_data_out);
        u_fb.rd(1'b0, 1'b0);
        chk("offset b", 9'h003, ob.read_data_out);
        u_fb.wr(1'b1, 1'b1, 9'h0EE);
        u_fb.wr(1'b0, 1'b1, 9'h011);
        u_fb.wr(1'b0, 1'b1, 9'h022);
        u_fb.rd(1'b1, 1'b1);
        chk("flags b", 9'h00E, flags(ob));
        u_fb.wr(1'b0, 1'b1, 9'h033);
        u_fb.rd(1'b1, 1'b1);
        chk("flags b", 9'h00F, flags(ob));
        u_fb.rd(1'b0, 1'b0);
        chk("data b", 9'h011, ob.read_data_out);
        u_fb.rst(1'b0);
        u_fb.rd(1'b0, 1'b0);
        chk("offset b", 9'h007, ob.read_data_out);
        chk("bus b", 9'h007, qb);
    endtask : t_load

    // a write clock pulse while the enable is low must leave no trace
    task automatic t_freeze;
        ce <= 1'b0;
        u_fa.wr(1'b0, 1'b1, 9'h0C3);
        ce <= 1'b1;
        u_fa.rd(1'b1, 1'b1);
        chk("flags a", 9'h008, flags(oa));
    endtask : t_freeze

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // run needs about 7000 cycles
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        fail_count++;
        $display("Error watchdog expected finish seen hang");
        results();
    end

    initial begin
        sys_rst_i = 1'b1;
        ce = 1'b1;
        fail_count = 0;
        checks_done = 0;
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        u_fa.rst(1'b1);
        u_fb.rst(1'b0);
        t_reset();
        t_order();
        t_fill();
        t_freeze();
        t_load();
        results();
    end
endmodule : dsf_dual_fifo_tb
